// file: verilog/eilg_device_end.sv
// glue logic beside the processor: external instruction decode and load code generator
// assumes processor pins arrive asynchronously, user interrupt code is on CORE_CLK
`timescale 1ns/1ns
module eilg_device_end #(
   parameter int DEB_CYCLES = eilg_pkg::DEB_CYCLES,
   parameter int STRETCH_CYCLES = eilg_pkg::STRETCH_CYCLES
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic CE,
   // processor side
   eilg_link_if.device LINK,
   // board side inputs
   input wire logic [2:0] USER_INT_CODE,
   input wire logic SUPPLY_SETTLED,
   input wire logic LOAD_SWITCH_N,
   // board side outputs
   output logic IO_DEVICE_STROBE,
   output logic FORWARD_INDICATOR,
   output logic TAPE_MOTOR_CONTROL_N,
   output logic IDLE_INDICATOR,
   output logic LOAD_REQUEST_N,
   output logic USER_SPARE_PULSE,
   output logic RESET_OUT_N,
   output logic LOAD_ACTIVE
);
   // ***************************************
   // decode helpers
   // ***************************************
   localparam int DEC_ON = 0;
   localparam int DEC_OFF = 1;
   localparam int DEC_IDLE = 2;
   localparam int DEC_LOAD = 3;
   localparam int DEC_SPARE = 4;

   // one-hot decode, all zero for serial I/O codes
   function automatic logic [4:0] ext_decode(input logic [2:0] c);
      logic [4:0] r;
      r = 5'h00;
      case (c)
         eilg_pkg::EXT_OP_FORWARD_ON: r[DEC_ON] = 1'b1;
         eilg_pkg::EXT_OP_FORWARD_OFF: r[DEC_OFF] = 1'b1;
         eilg_pkg::EXT_OP_IDLE: r[DEC_IDLE] = 1'b1;
         eilg_pkg::EXT_OP_LOAD_REQUEST: r[DEC_LOAD] = 1'b1;
         eilg_pkg::EXT_OP_USER_SPARE: r[DEC_SPARE] = 1'b1;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   generate
      if (DEB_CYCLES < 1 || STRETCH_CYCLES < 1) begin : g_chk
         $error("eilg_device_end: counts must be at least 1");
      end
   endgenerate

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic [7:0] pins_f;
   logic [1:0] addr_f;
   logic sob_f, strobe_f, fetch_f, ph3_n_f, supply_f, switch_n_f;

   eilg_pin_sync #(.WIDTH(8), .INIT(8'hc0)) u_sync (
      .clk(CORE_CLK),
      .reset_n(RESET_N),
      .ce(CE),
      .d({LOAD_SWITCH_N, LINK.phase3_n, SUPPLY_SETTLED, LINK.fetch_cycle_flag,
          LINK.serial_io_strobe, LINK.serial_out_bit_addr_lsb, LINK.addr_hi}),
      .q(pins_f)
   );
   assign addr_f = pins_f[1:0];
   assign sob_f = pins_f[2];
   assign strobe_f = pins_f[3];
   assign fetch_f = pins_f[4];
   assign supply_f = pins_f[5];
   assign ph3_n_f = pins_f[6];
   assign switch_n_f = pins_f[7];

   // ***************************************
   // edges and phase-3 sampling
   // ***************************************
   logic strobe_d_r, ph3_n_d_r, ps_sync_r, ps_sync_d_r, fetch_sync_r, fetch_sync_d_r;
   logic ph3_fall, strobe_rise, ps_rise, fetch_rise;
   logic [4:0] dec;

   assign ph3_fall = ph3_n_d_r & ~ph3_n_f;
   assign strobe_rise = strobe_f & ~strobe_d_r;
   assign ps_rise = ps_sync_r & ~ps_sync_d_r;
   assign fetch_rise = fetch_sync_r & ~fetch_sync_d_r;
   assign dec = strobe_rise ? ext_decode({addr_f, sob_f}) : 5'h00;

   // supply and fetch taken only at the phase-3 edge
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         strobe_d_r <= 1'b0;
         ph3_n_d_r <= 1'b1;
         ps_sync_r <= 1'b0;
         ps_sync_d_r <= 1'b0;
         fetch_sync_r <= 1'b0;
         fetch_sync_d_r <= 1'b0;
      end else if (CE) begin
         strobe_d_r <= strobe_f;
         ph3_n_d_r <= ph3_n_f;
         ps_sync_d_r <= ps_sync_r;
         fetch_sync_d_r <= fetch_sync_r;
         if (ph3_fall) begin
            ps_sync_r <= supply_f;
            fetch_sync_r <= fetch_f;
         end
      end
   end

   // ***************************************
   // strobe gate, forward flop, spare
   // ***************************************
   // external codes always have a top address bit set, so gating on both blocks them
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         IO_DEVICE_STROBE <= 1'b0;
         USER_SPARE_PULSE <= 1'b0;
      end else if (CE) begin
         IO_DEVICE_STROBE <= strobe_f & (addr_f == 2'h0);
         USER_SPARE_PULSE <= dec[DEC_SPARE];
      end
   end

   // forward flop: either decode clocks it, the on decode is the data
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FORWARD_INDICATOR <= 1'b0;
         TAPE_MOTOR_CONTROL_N <= 1'b1;
      end else if (CE && (dec[DEC_ON] | dec[DEC_OFF])) begin
         FORWARD_INDICATOR <= dec[DEC_ON];
         TAPE_MOTOR_CONTROL_N <= ~dec[DEC_ON];
      end
   end

   // ***************************************
   // idle stretcher
   // ***************************************
   logic [31:0] stretch_r;

   // every repeated idle pulse reloads, so the lamp stays solid while idle if STRETCH_CYCLES is at least the 12-cycle repeat
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stretch_r <= 32'h0;
         IDLE_INDICATOR <= 1'b0;
      end else if (CE) begin
         if (dec[DEC_IDLE]) begin
            stretch_r <= 32'(STRETCH_CYCLES);
         end else if (stretch_r != 32'h0) begin
            stretch_r <= stretch_r - 32'h1;
         end
         IDLE_INDICATOR <= dec[DEC_IDLE] | (stretch_r > 32'h1);
      end
   end

   // ***************************************
   // switch debounce and load request
   // ***************************************
   logic [31:0] deb_cnt_r;
   logic switch_db_n_r, load_req_d_r;

   // switch must hold a new level for the full count before it is believed
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         deb_cnt_r <= 32'h0;
         switch_db_n_r <= 1'b1;
      end else if (CE) begin
         if (switch_n_f == switch_db_n_r) begin
            deb_cnt_r <= 32'h0;
         end else if (deb_cnt_r >= 32'(DEB_CYCLES - 1)) begin
            deb_cnt_r <= 32'h0;
            switch_db_n_r <= switch_n_f;
         end else begin
            deb_cnt_r <= deb_cnt_r + 32'h1;
         end
      end
   end

   // request low from the load code or the debounced switch
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LOAD_REQUEST_N <= 1'b1;
         load_req_d_r <= 1'b1;
      end else if (CE) begin
         LOAD_REQUEST_N <= ~dec[DEC_LOAD] & switch_db_n_r;
         load_req_d_r <= LOAD_REQUEST_N;
      end
   end

   // ***************************************
   // load delay chain
   // ***************************************
   logic capture_r, stage1_r, pu_load_r;

   // a held request sets capture once; only its falling edge counts
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         capture_r <= 1'b0;
         stage1_r <= 1'b0;
         LOAD_ACTIVE <= 1'b0;
         pu_load_r <= 1'b0;
      end else if (CE) begin
         if (!ps_sync_r) begin
            capture_r <= 1'b0;
            stage1_r <= 1'b0;
            LOAD_ACTIVE <= 1'b0;
            pu_load_r <= 1'b0;
         end else if (fetch_rise && LOAD_ACTIVE) begin
            capture_r <= load_req_d_r & ~LOAD_REQUEST_N; // new request wins
            stage1_r <= 1'b0;
            LOAD_ACTIVE <= 1'b0;
            pu_load_r <= 1'b0;
         end else begin
            if ((load_req_d_r & ~LOAD_REQUEST_N) | ps_rise) begin
               capture_r <= 1'b1;
            end
            if (ps_rise) begin
               pu_load_r <= 1'b1;
            end
            if (fetch_rise) begin
               stage1_r <= capture_r;
               LOAD_ACTIVE <= stage1_r;
            end
         end
      end
   end

   // ***************************************
   // interrupt code and reset outputs
   // ***************************************
   // reset beats load, load beats the user port code
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.int_code_lines <= eilg_pkg::INT_RESET;
         RESET_OUT_N <= 1'b0;
      end else if (CE) begin
         RESET_OUT_N <= supply_f;
         if (!ps_sync_r) begin
            LINK.int_code_lines <= eilg_pkg::INT_RESET;
         end else if (pu_load_r | LOAD_ACTIVE | ps_rise) begin
            LINK.int_code_lines <= eilg_pkg::INT_LOAD;
         end else begin
            LINK.int_code_lines <= USER_INT_CODE;
         end
      end
   end
endmodule

// file: verilog/eilg_pkg.sv
// shared constants for the external-instruction decoder and load code generator
// assumes one 100 MHz core clock on both ends of the link
package eilg_pkg;
   // ***************************************
   // timing
   // ***************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEBOUNCE_US = 10000;
   localparam int DEB_CYCLES = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
   localparam int IDLE_STRETCH_US = 50;
   localparam int STRETCH_CYCLES = IDLE_STRETCH_US * 1000 / CLK_PERIOD_NS;
   localparam int PH3_HALF_CYCLES = 4;
   localparam int STROBE_CYCLES = 4;
   // ***************************************
   // external instruction codes {addr_hi, serial_out_bit_addr_lsb}
   // ***************************************
   localparam logic [2:0] EXT_OP_IDLE = 3'h2;
   localparam logic [2:0] EXT_OP_USER_SPARE = 3'h3;
   localparam logic [2:0] EXT_OP_FORWARD_ON = 3'h5;
   localparam logic [2:0] EXT_OP_FORWARD_OFF = 3'h6;
   localparam logic [2:0] EXT_OP_LOAD_REQUEST = 3'h7;
   // ***************************************
   // interrupt codes
   // ***************************************
   localparam logic [2:0] INT_RESET = 3'h0;
   localparam logic [2:0] INT_LOAD = 3'h2;
   localparam logic [2:0] INT_NONE = 3'h7;
   // ***************************************
   // host register map and fields
   // ***************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int CTRL_FETCH_BIT = 0;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_IDLE_BIT = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/eilg_link_if.sv
// processor pins between the host end and the glue-logic end
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface eilg_link_if;
   logic [1:0] addr_hi;
   logic serial_out_bit_addr_lsb;
   logic serial_io_strobe;
   logic fetch_cycle_flag;
   logic phase3_n;
   logic [2:0] int_code_lines;
   modport host (
      output addr_hi, serial_out_bit_addr_lsb, serial_io_strobe, fetch_cycle_flag, phase3_n,
      input int_code_lines
   );
   modport device (
      input addr_hi, serial_out_bit_addr_lsb, serial_io_strobe, fetch_cycle_flag, phase3_n,
      output int_code_lines
   );
endinterface

// file: verilog/eilg_pin_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes asynchronous inputs; output moves only when stages two and three agree
`timescale 1ns/1ns
module eilg_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_r, s2_r, s3_r;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("eilg_pin_sync: WIDTH must be at least 1");
      end
   endgenerate

   // s1 feeds s2 only; filtering looks at s2 and s3
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         q <= INIT;
      end else if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// file: verilog/eilg_host_end.sv
// processor-side end: drives code, strobe, fetch flag and phase-3 clock from registers
// assumes an AXI4-Lite master on CORE_CLK and the glue end on the same clock
`timescale 1ns/1ns
module eilg_host_end (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic CE,
   // processor pins
   eilg_link_if.host LINK,
   // axi4-lite slave
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [3:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   typedef enum logic [1:0] {S_REST = 2'h0, S_SETUP = 2'h1, S_STROBE = 2'h3, S_HOLD = 2'h2}
      eilg_cyc_e;
   eilg_cyc_e st_r;
   logic [3:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [7:0] cnt_r, ph3_cnt_r;
   logic aw_got_r, w_got_r, idle_rep_r, do_wr, cmd_wr;

   // ***************************************
   // write channel
   // ***************************************
   assign do_wr = aw_got_r & w_got_r & ~BVALID;
   assign cmd_wr = do_wr & (awaddr_r == eilg_pkg::REG_CMD) & WSTRB[0];

   // address and data taken in either order, response after both
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0;
         BVALID <= 1'b0;
         BRESP <= eilg_pkg::RESP_OKAY;
      end else if (CE) begin
         if (AWVALID && AWREADY) begin
            aw_got_r <= 1'b1;
            AWREADY <= 1'b0;
            awaddr_r <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_got_r <= 1'b1;
            WREADY <= 1'b0;
            wdata_r <= WDATA;
         end
         if (do_wr) begin
            BVALID <= 1'b1;
            BRESP <= (awaddr_r == eilg_pkg::REG_CTRL || awaddr_r == eilg_pkg::REG_CMD ||
                      awaddr_r == eilg_pkg::REG_STATUS) ? eilg_pkg::RESP_OKAY
                                                         : eilg_pkg::RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // fetch flag level set by software
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.fetch_cycle_flag <= 1'b0;
      end else if (CE && do_wr && awaddr_r == eilg_pkg::REG_CTRL && WSTRB[0]) begin
         LINK.fetch_cycle_flag <= wdata_r[eilg_pkg::CTRL_FETCH_BIT];
      end
   end

   // ***************************************
   // read channel
   // ***************************************
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0;
         RRESP <= eilg_pkg::RESP_OKAY;
      end else if (CE) begin
         if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= eilg_pkg::RESP_OKAY;
            case (ARADDR)
               eilg_pkg::REG_CTRL: RDATA <= {31'h0, LINK.fetch_cycle_flag};
               eilg_pkg::REG_CMD: RDATA <= {29'h0, LINK.addr_hi, LINK.serial_out_bit_addr_lsb};
               eilg_pkg::REG_STATUS: RDATA <= {27'h0, idle_rep_r, st_r != S_REST,
                                               LINK.int_code_lines};
               default: begin
                  RDATA <= 32'h0;
                  RRESP <= eilg_pkg::RESP_SLVERR;
               end
            endcase
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

   // ***************************************
   // phase-3 clock and strobe sequencer
   // ***************************************
   // free-running divided clock; no second domain on this end
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ph3_cnt_r <= 8'h0;
         LINK.phase3_n <= 1'b1;
      end else if (CE) begin
         if (ph3_cnt_r == 8'(eilg_pkg::PH3_HALF_CYCLES - 1)) begin
            ph3_cnt_r <= 8'h0;
            LINK.phase3_n <= ~LINK.phase3_n;
         end else begin
            ph3_cnt_r <= ph3_cnt_r + 8'h1;
         end
      end
   end

   // commands while busy are dropped; idle repeats until any usable code
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r <= S_REST;
         cnt_r <= 8'h0;
         idle_rep_r <= 1'b0;
         LINK.addr_hi <= 2'h0;
         LINK.serial_out_bit_addr_lsb <= 1'b0;
         LINK.serial_io_strobe <= 1'b0;
      end else if (CE) begin
         case (st_r)
            S_REST: begin
               if (cmd_wr) begin
                  LINK.addr_hi <= wdata_r[2:1];
                  LINK.serial_out_bit_addr_lsb <= wdata_r[0];
                  idle_rep_r <= wdata_r[2:0] == eilg_pkg::EXT_OP_IDLE;
                  cnt_r <= 8'h0;
                  st_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               cnt_r <= cnt_r + 8'h1;
               if (cnt_r == 8'(eilg_pkg::STROBE_CYCLES - 1)) begin
                  cnt_r <= 8'h0;
                  LINK.serial_io_strobe <= 1'b1;
                  st_r <= S_STROBE;
               end
            end
            S_STROBE: begin
               cnt_r <= cnt_r + 8'h1;
               if (cnt_r == 8'(eilg_pkg::STROBE_CYCLES - 1)) begin
                  cnt_r <= 8'h0;
                  LINK.serial_io_strobe <= 1'b0;
                  st_r <= S_HOLD;
               end
            end
            S_HOLD: begin
               cnt_r <= cnt_r + 8'h1;
               if (cnt_r == 8'(eilg_pkg::STROBE_CYCLES - 1)) begin
                  cnt_r <= 8'h0;
                  if (idle_rep_r && LINK.int_code_lines == eilg_pkg::INT_NONE) begin
                     st_r <= S_SETUP;
                  end else begin
                     idle_rep_r <= 1'b0;
                     LINK.addr_hi <= 2'h0;
                     st_r <= S_REST;
                  end
               end
            end
            default: st_r <= S_REST;
         endcase
      end
   end
endmodule

// file: tb/eilg_assertions.sv
// concurrent checks on the processor link between the two ends
// assumes one clock; instantiated by tb beside the link interface
`timescale 1ns/1ns
module eilg_assertions (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // link signals
   input wire logic [1:0] addr_hi,
   input wire logic serial_out_bit_addr_lsb,
   input wire logic serial_io_strobe,
   input wire logic fetch_cycle_flag,
   input wire logic phase3_n,
   input wire logic [2:0] int_code_lines
);
   // ***************************************
   // strobe and code timing
   // ***************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // code as the decoder sees it
   wire logic [2:0] code = {addr_hi, serial_out_bit_addr_lsb};
   property p_strobe_len;
      $rose(serial_io_strobe) |-> serial_io_strobe[*4] ##1 !serial_io_strobe;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
   property p_strobe_gap;
      $fell(serial_io_strobe) |-> !serial_io_strobe[*4];
   endproperty
   a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
   property p_setup;
      $rose(serial_io_strobe) |-> $past(code, 3) == code;
   endproperty
   a_setup: assert property (p_setup) else $error("code not set up");
   property p_code_stable;
      serial_io_strobe |-> $stable(code);
   endproperty
   a_code_stable: assert property (p_code_stable) else $error("code moved in strobe");
   // ***************************************
   // phase-3 clock, idle and load release
   // ***************************************
   property p_ph3_low;
      $fell(phase3_n) |-> !phase3_n[*4] ##1 phase3_n;
   endproperty
   a_ph3_low: assert property (p_ph3_low) else $error("phase3 low time wrong");
   property p_ph3_high;
      $rose(phase3_n) |-> phase3_n[*4] ##1 !phase3_n;
   endproperty
   a_ph3_high: assert property (p_ph3_high) else $error("phase3 high time wrong");
   // idle may stop only because the interrupt code changed
   property p_idle_repeat;
      $fell(serial_io_strobe) && code == eilg_pkg::EXT_OP_IDLE
         && int_code_lines == eilg_pkg::INT_NONE
         |-> ##[1:12] ($rose(serial_io_strobe) || int_code_lines != eilg_pkg::INT_NONE);
   endproperty
   a_idle_repeat: assert property (p_idle_repeat) else $error("idle not repeated");
   sequence s_load_drop;
      int_code_lines == eilg_pkg::INT_LOAD ##1
         (int_code_lines != eilg_pkg::INT_LOAD && int_code_lines != eilg_pkg::INT_RESET);
   endsequence
   property p_load_release;
      s_load_drop |-> $past(fetch_cycle_flag, 2);
   endproperty
   a_load_release: assert property (p_load_release) else $error("load left without fetch");
endmodule

// file: tb/tb.sv
// self-checking bench: both ends joined by the link, host end driven over axi4-lite
// assumes small debounce and stretch counts so the run stays short
`timescale 1ns/1ns
module tb;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] user_code = 3'h7;
   logic supply = 1'b0;
   logic switch_n = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd_word;
   logic io_strobe, forward_indicator, tape_n, idle_ind, lreq_n, spare, rst_out_n, load_act, fwd_exp;
   logic [3:0] seen;
   logic [2:0] ops [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   eilg_link_if link();
   eilg_host_end i_eilg_host_end (.CORE_CLK(core_clk), .RESET_N(reset_n), .CE(1'b1),
      .LINK(link.host), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   eilg_device_end #(.DEB_CYCLES(4), .STRETCH_CYCLES(8)) i_eilg_device_end (
      .CORE_CLK(core_clk), .RESET_N(reset_n), .CE(1'b1), .LINK(link.device),
      .USER_INT_CODE(user_code), .SUPPLY_SETTLED(supply), .LOAD_SWITCH_N(switch_n),
      .IO_DEVICE_STROBE(io_strobe), .FORWARD_INDICATOR(forward_indicator), .TAPE_MOTOR_CONTROL_N(tape_n),
      .IDLE_INDICATOR(idle_ind), .LOAD_REQUEST_N(lreq_n), .USER_SPARE_PULSE(spare),
      .RESET_OUT_N(rst_out_n), .LOAD_ACTIVE(load_act));
   eilg_assertions i_eilg_assertions (.CORE_CLK(core_clk), .RESET_N(reset_n),
      .addr_hi(link.addr_hi), .serial_out_bit_addr_lsb(link.serial_out_bit_addr_lsb),
      .serial_io_strobe(link.serial_io_strobe), .fetch_cycle_flag(link.fetch_cycle_flag),
      .phase3_n(link.phase3_n), .int_code_lines(link.int_code_lines));
   // ***************************************
   // clock, timeout and helpers
   // ***************************************
   always #5 core_clk = ~core_clk;
   // a hung handshake would otherwise stall the run for ever
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits and gathers every pulse the decoder gives meanwhile
   task automatic run(input int n);
      repeat (n) begin
         @(posedge core_clk);
         seen = seen | {io_strobe, spare, ~lreq_n, idle_ind};
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      r = bresp;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   task automatic op(input logic [2:0] c);
      wr(eilg_pkg::REG_CMD, {29'h0, c}, resp);
      chk(resp, eilg_pkg::RESP_OKAY);
      seen = 4'h0;
      run(40);
   endtask
   task automatic fetch();
      wr(eilg_pkg::REG_CTRL, 32'h1, resp);
      run(40);
      wr(eilg_pkg::REG_CTRL, 32'h0, resp);
      run(40);
   endtask
   // load code must wait two fetches, then leave at the third
   task automatic load_chain();
      fetch();
      chk(load_act, 1'b0);
      fetch();
      chk(load_act, 1'b1);
      chk(link.int_code_lines, eilg_pkg::INT_LOAD);
      fetch();
      chk(load_act, 1'b0);
      chk(link.int_code_lines, user_code);
   endtask
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      run(10);
      chk(link.int_code_lines, eilg_pkg::INT_RESET);
      chk(rst_out_n, 1'b0);
      supply <= 1'b1;
      run(20);
      chk(rst_out_n, 1'b1);
      chk(link.int_code_lines, eilg_pkg::INT_LOAD);
      load_chain();
      for (int c = 3; c < 8; c++) begin
         user_code <= c[2:0];
         run(10);
         rd(eilg_pkg::REG_STATUS, rd_word, resp);
         chk(rd_word[2:0], c);
      end
      fwd_exp = 1'b0;
      for (int i = 0; i < 6; i++) begin
         op(ops[i]);
         if (ops[i] == eilg_pkg::EXT_OP_FORWARD_ON) fwd_exp = 1'b1;
         if (ops[i] == eilg_pkg::EXT_OP_FORWARD_OFF) fwd_exp = 1'b0;
         chk(seen, {ops[i][2:1] == 2'h0, ops[i] == eilg_pkg::EXT_OP_USER_SPARE, 2'h0});
         chk(forward_indicator, fwd_exp);
         chk(tape_n, !fwd_exp);
      end
      op(eilg_pkg::EXT_OP_IDLE);
      chk(seen, 4'h1);
      rd(eilg_pkg::REG_STATUS, rd_word, resp);
      chk(rd_word[4], 1'b1);
      user_code <= 3'h3;
      run(60);
      chk(idle_ind, 1'b0);
      op(eilg_pkg::EXT_OP_LOAD_REQUEST);
      chk(seen, 4'h2);
      load_chain();
      // switch held low: only one load sequence may follow
      switch_n <= 1'b0;
      seen = 4'h0;
      run(30);
      chk(seen[1], 1'b1);
      load_chain();
      fetch();
      fetch();
      chk(load_act, 1'b0);
      chk(link.int_code_lines, user_code);
      switch_n <= 1'b1;
      wr(4'hc, 32'h5, resp);
      chk(resp, eilg_pkg::RESP_SLVERR);
      rd(4'hc, rd_word, resp);
      chk(resp, eilg_pkg::RESP_SLVERR);
      supply <= 1'b0;
      run(20);
      chk(rst_out_n, 1'b0);
      chk(link.int_code_lines, eilg_pkg::INT_RESET);
      print_verdict();
   end
endmodule
